// *** logic/io_port.sv ***
// six-bit i/o port with direction control, pull-ups and pin-change wake
// Overview of operation
// - first port: bits 5..0 pins, 7..6 read zero
// - second port same layout on larger variant
// - port read returns pin levels, not latches
// - pin level taken at the read only
// - output latch holds until rewritten
// - every pin is an input after reset
// - first-port pin three is input only
// - alternate-function pins read as zero
// - one shared pull-up enable and one shared wake enable
// - master clear forces pull-up, drops wake
// - direction load copies working register
// - direction one floats, zero drives latch
// - timer source may override timer pin direction
// - direction registers write-only, reset all ones
// - status bit seven flags pin-change wake reset
// - clear option bits enable wake and pull-up
// - output pins lose pull-up and wake
// - timer source one forces timer pin input
`timescale 1ns/1ps
`default_nettype none

module io_port
  import io_port_pkg::*;
#(
  parameter bit          LARGE_VARIANT = 1'b0,
  parameter bit          TIMER_BANK    = 1'b0,
  parameter int unsigned TIMER_PIN     = 2
)
(
  input  wire logic                               mclk,
  input  wire logic                               reset,
  input  wire logic [io_port_pkg::ADDR_WIDTH-1:0] file_addr,
  input  wire logic                               file_read,
  input  wire logic                               file_write,
  input  wire logic [io_port_pkg::REG_WIDTH-1:0]  file_wdata,
  output logic      [io_port_pkg::REG_WIDTH-1:0]  file_rdata,
  input  wire logic                               direction_load_instr,
  input  wire logic                               option_load,
  input  wire logic                               sleep_mode,
  input  wire logic                               wake_reset_cause,
  input  wire logic                               master_clear_input,
  input  wire logic [io_port_pkg::PORT_WIDTH-1:0] alt_func_one,
  input  wire logic [io_port_pkg::PORT_WIDTH-1:0] alt_func_two,
  input  wire logic [io_port_pkg::PORT_WIDTH-1:0] bank_one_pin_in,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] bank_one_pin_out,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] bank_one_pin_oe,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] bank_one_pullup_en,
  input  wire logic [io_port_pkg::PORT_WIDTH-1:0] bank_two_pin_in,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] bank_two_pin_out,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] bank_two_pin_oe,
  output logic      [io_port_pkg::REG_WIDTH-1:0]  option_cfg,
  output logic                                    timer_clock_source_sel,
  output logic                                    pin_wake_request,
  output logic                                    pin_wake_flag
);

  // ==========================================================================
  // elaboration checks
  generate
    if (TIMER_PIN >= PORT_WIDTH)
    begin : g_bad_timer_pin
      $error("timer pin index outside the port");
    end
    if (TIMER_BANK && !LARGE_VARIANT)
    begin : g_bad_timer_bank
      $error("second bank exists only on the larger variant");
    end
    if (!TIMER_BANK && TIMER_PIN == INPUT_ONLY_PIN)
    begin : g_bad_timer_input
      $error("timer pin cannot be the input-only pin");
    end
    if (INPUT_ONLY_PIN >= PORT_WIDTH)
    begin : g_bad_input_pin
      $error("input-only pin outside the port");
    end
    if (REG_WIDTH != PORT_WIDTH + 2)
    begin : g_bad_reg_width
      $error("port registers hold six pins and two zero bits");
    end
    if (WAKE_FLAG_BIT >= REG_WIDTH)
    begin : g_bad_flag_bit
      $error("wake flag outside the status register");
    end
    if (TIMER_SOURCE_BIT >= REG_WIDTH || WAKE_DISABLE_BIT >= REG_WIDTH
        || PULLUP_DISABLE_BIT >= REG_WIDTH)
    begin : g_bad_option_bit
      $error("option field outside the register");
    end
  endgenerate

  // ==========================================================================
  // helpers

  // one-hot mask of a single pin
  function automatic logic [PORT_WIDTH-1:0] pin_mask(input int unsigned idx);
    logic [PORT_WIDTH-1:0] m;
    m = '0;
    m[idx] = 1'b1;
    return m;
  endfunction

  // address match, shared by the register decoders
  function automatic logic addr_is(
    input logic [ADDR_WIDTH-1:0] addr,
    input logic [ADDR_WIDTH-1:0] target
  );
    return addr == target;
  endfunction

  // eight-bit port read: pins masked by alternate function, top bits zero
  function automatic logic [REG_WIDTH-1:0] port_read_value(
    input logic [PORT_WIDTH-1:0] pins,
    input logic [PORT_WIDTH-1:0] alt
  );
    return {2'b00, pins & ~alt};
  endfunction

  localparam logic [PORT_WIDTH-1:0] TIMER_MASK     = pin_mask(TIMER_PIN);
  localparam logic [PORT_WIDTH-1:0] CLEAR_PIN_MASK = pin_mask(INPUT_ONLY_PIN);
  localparam logic [PORT_WIDTH-1:0] WAKE_GROUP =
    LARGE_VARIANT ? WAKE_GROUP_LARGE : WAKE_GROUP_SMALL;

  // ==========================================================================
  // address decode
  // direction loads and port accesses share these matches
  wire hit_status   = addr_is(file_addr, STATUS_ADDR);
  wire hit_bank_one = addr_is(file_addr, BANK_ONE_ADDR);
  wire hit_bank_two = LARGE_VARIANT && addr_is(file_addr, BANK_TWO_ADDR);

  wire write_one = file_write && hit_bank_one;
  wire write_two = file_write && hit_bank_two;
  wire read_one  = file_read && hit_bank_one;
  wire read_two  = file_read && hit_bank_two;
  wire dir_one   = direction_load_instr && hit_bank_one;
  wire dir_two   = direction_load_instr && hit_bank_two;

  // ==========================================================================
  // option register, write-only from the working register
  // only the two enables and the timer source are used here
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      option_cfg <= OPTION_RESET;
    else if (option_load)
      option_cfg <= file_wdata;
  end

  wire wake_enabled   = ~option_cfg[WAKE_DISABLE_BIT];
  wire pullup_enabled = ~option_cfg[PULLUP_DISABLE_BIT];

  assign timer_clock_source_sel = option_cfg[TIMER_SOURCE_BIT];

  // ==========================================================================
  // bank one
  logic [PORT_WIDTH-1:0] latch_one;
  logic [PORT_WIDTH-1:0] dir_reg_one;
  logic [PORT_WIDTH-1:0] snap_one;

  pin_bank #(
    .OUT_CAPABLE (OUTPUT_MASK)
  ) u_bank_one (
    .mclk        (mclk),
    .reset       (reset),
    .write_en    (write_one),
    .dir_load_en (dir_one),
    .read_en     (read_one),
    .wdata       (file_wdata[PORT_WIDTH-1:0]),
    .pin_in      (bank_one_pin_in),
    .out_latch   (latch_one),
    .dir         (dir_reg_one),
    .snapshot    (snap_one)
  );

  // ==========================================================================
  // bank two, present only on the larger variant
  logic [PORT_WIDTH-1:0] latch_two;
  logic [PORT_WIDTH-1:0] dir_reg_two;

  generate
    if (LARGE_VARIANT)
    begin : g_bank_two
      pin_bank #(
        .OUT_CAPABLE (ALL_OUTPUTS)
      ) u_bank_two (
        .mclk        (mclk),
        .reset       (reset),
        .write_en    (write_two),
        .dir_load_en (dir_two),
        .read_en     (read_two),
        .wdata       (file_wdata[PORT_WIDTH-1:0]),
        .pin_in      (bank_two_pin_in),
        .out_latch   (latch_two),
        .dir         (dir_reg_two),
        .snapshot    ()
      );
    end
    else
    begin : g_no_bank_two
      // absent bank: latches zero, directions idle as inputs
      assign latch_two   = '0;
      assign dir_reg_two = DIR_RESET;
    end
  endgenerate

  // ==========================================================================
  // effective direction: timer source forces its pin to input
  // only the bank that holds the timer pin is forced
  wire                  timer_force = option_cfg[TIMER_SOURCE_BIT];
  wire [PORT_WIDTH-1:0] force_one =
    (!TIMER_BANK && timer_force) ? TIMER_MASK : '0;
  wire [PORT_WIDTH-1:0] force_two =
    (TIMER_BANK && timer_force) ? TIMER_MASK : '0;

  wire [PORT_WIDTH-1:0] eff_dir_one = dir_reg_one | force_one;
  wire [PORT_WIDTH-1:0] eff_dir_two = dir_reg_two | force_two;

  // ==========================================================================
  // output drivers
  assign bank_one_pin_out = latch_one;
  assign bank_two_pin_out = latch_two;

  // ==========================================================================
  // per-pin controls of bank one
  wire [PORT_WIDTH-1:0] clear_pins =
    master_clear_input ? CLEAR_PIN_MASK : '0;
  wire [PORT_WIDTH-1:0] oe_one;
  wire [PORT_WIDTH-1:0] pullup_one;
  wire [PORT_WIDTH-1:0] wake_pins;

  generate
    for (genvar i = 0; i < PORT_WIDTH; i++)
    begin : g_pin_one
      // pin three has no driver and ignores its direction bit, so its
      // pull-up and wake follow the shared enables and the master clear input
      wire input_only = (i == INPUT_ONLY_PIN);
      wire as_input   = eff_dir_one[i] || input_only;
      wire may_drive  = OUTPUT_MASK[i] && !input_only;

      // driver on when direction is zero, the pin can drive and no alternate use
      assign oe_one[i] =
        !eff_dir_one[i] && may_drive && !alt_func_one[i];
      assign pullup_one[i] =
        (pullup_enabled && WAKE_GROUP[i] && as_input)
        || clear_pins[i];
      assign wake_pins[i] =
        wake_enabled && WAKE_GROUP[i] && as_input
        && !clear_pins[i];
    end
  endgenerate

  assign bank_one_pin_oe    = oe_one;
  assign bank_one_pullup_en = pullup_one;

  // ==========================================================================
  // per-pin drivers of bank two, all off on the small variant
  wire [PORT_WIDTH-1:0] oe_two;

  generate
    for (genvar j = 0; j < PORT_WIDTH; j++)
    begin : g_pin_two
      assign oe_two[j] =
        LARGE_VARIANT && !eff_dir_two[j] && !alt_func_two[j];
    end
  endgenerate

  assign bank_two_pin_oe = oe_two;

  // ==========================================================================
  // wake on change
  // a read re-arms the detector: only a change since then can wake the core

  wire pin_changed = |((bank_one_pin_in ^ snap_one) & wake_pins);

  logic next_wake_request;
  assign next_wake_request = sleep_mode && pin_changed;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pin_wake_request <= 1'b0;
    else
      pin_wake_request <= next_wake_request;
  end

  // ==========================================================================
  // reset cause flag, caught on the first edge after reset release
  // the cause is held across release, so it is loaded exactly once
  logic first_cycle;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      first_cycle <= 1'b1;
    else
      first_cycle <= 1'b0;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pin_wake_flag <= 1'b0;
    else if (first_cycle)
      pin_wake_flag <= wake_reset_cause;
  end

  // ==========================================================================
  // read data: pins sampled at the read, never the latches
  wire [REG_WIDTH-1:0] status_value =
    REG_WIDTH'(pin_wake_flag) << WAKE_FLAG_BIT;
  wire [REG_WIDTH-1:0] read_one_value =
    port_read_value(bank_one_pin_in, alt_func_one);
  wire [REG_WIDTH-1:0] read_two_value =
    port_read_value(bank_two_pin_in, alt_func_two);

  logic [REG_WIDTH-1:0] next_rdata;

  always_comb
  begin
    if (read_one)
      next_rdata = read_one_value;
    else if (read_two)
      next_rdata = read_two_value;
    else if (file_read && hit_status)
      next_rdata = status_value;
    else
      next_rdata = '0;
  end

  // read data stand until the next read instruction
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      file_rdata <= '0;
    else if (file_read)
      file_rdata <= next_rdata;
  end

endmodule : io_port
`default_nettype wire

// *** logic/pin_bank.sv ***
// one six-bit bank: output latch, direction latch and read snapshot
`timescale 1ns/1ps
`default_nettype none

module pin_bank
  import io_port_pkg::*;
#(
  parameter logic [io_port_pkg::PORT_WIDTH-1:0] OUT_CAPABLE = 6'h3F
)
(
  input  wire logic                              mclk,
  input  wire logic                              reset,
  input  wire logic                              write_en,
  input  wire logic                              dir_load_en,
  input  wire logic                              read_en,
  input  wire logic [io_port_pkg::PORT_WIDTH-1:0] wdata,
  input  wire logic [io_port_pkg::PORT_WIDTH-1:0] pin_in,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] out_latch,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] dir,
  output logic      [io_port_pkg::PORT_WIDTH-1:0] snapshot
);

  // ==========================================================================
  // output data latches
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      out_latch <= '0;
    else if (write_en)
      out_latch <= wdata & OUT_CAPABLE;
  end

  // ==========================================================================
  // direction latch, loaded only by the direction-load instruction
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      dir <= DIR_RESET;
    else if (dir_load_en)
      dir <= wdata;
  end

  // ==========================================================================
  // pin level seen at the most recent port read
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      snapshot <= '0;
    else if (read_en)
      snapshot <= pin_in;
  end

endmodule : pin_bank
`default_nettype wire

// *** shared/io_port_pkg.sv ***
// constants shared by the six-bit i/o port block
package io_port_pkg;

  localparam int unsigned ADDR_WIDTH = 5;
  localparam int unsigned REG_WIDTH  = 8;
  localparam int unsigned PORT_WIDTH = 6;

  // ==========================================================================
  // register file addresses
  localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR   = 5'h03;
  localparam logic [ADDR_WIDTH-1:0] BANK_ONE_ADDR = 5'h06;
  localparam logic [ADDR_WIDTH-1:0] BANK_TWO_ADDR = 5'h07;

  // ==========================================================================
  // option register fields
  localparam int unsigned WAKE_DISABLE_BIT   = 7;
  localparam int unsigned PULLUP_DISABLE_BIT = 6;
  localparam int unsigned TIMER_SOURCE_BIT   = 5;

  // status register fields
  localparam int unsigned WAKE_FLAG_BIT = 7;

  // ==========================================================================
  // reset values
  localparam logic [PORT_WIDTH-1:0] DIR_RESET    = 6'h3F;
  localparam logic [REG_WIDTH-1:0]  OPTION_RESET = 8'hFF;

  // ==========================================================================
  // pin groups of the first bank, and the second bank's output set
  localparam int unsigned           INPUT_ONLY_PIN   = 3;
  localparam logic [PORT_WIDTH-1:0] OUTPUT_MASK      = 6'h37;
  localparam logic [PORT_WIDTH-1:0] WAKE_GROUP_SMALL = 6'h0B;
  localparam logic [PORT_WIDTH-1:0] WAKE_GROUP_LARGE = 6'h1B;
  localparam logic [PORT_WIDTH-1:0] ALL_OUTPUTS      = 6'h3F;

endpackage : io_port_pkg

// *** tb/io_port_chk.sv ***
// concurrent checks on the ports of the six-bit i/o port
`timescale 1ns/1ps
`default_nettype none

module io_port_chk
  import io_port_pkg::*;
#(
  parameter bit          TIMER_BANK = 1'b0,
  parameter int unsigned TIMER_PIN  = 2
)
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [4:0] file_addr,
  input wire logic       file_read,
  input wire logic       file_write,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata,
  input wire logic       direction_load_instr,
  input wire logic       sleep_mode,
  input wire logic       wake_reset_cause,
  input wire logic       master_clear_input,
  input wire logic [5:0] alt_func_one,
  input wire logic [5:0] bank_one_pin_in,
  input wire logic [5:0] bank_one_pin_out,
  input wire logic [5:0] bank_one_pin_oe,
  input wire logic [5:0] bank_one_pullup_en,
  input wire logic [5:0] bank_two_pin_oe,
  input wire logic [7:0] option_cfg,
  input wire logic       timer_clock_source_sel,
  input wire logic       pin_wake_request,
  input wire logic       pin_wake_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  logic [5:0] exp_pins;

  // levels the next bank-one read has to return
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      exp_pins <= 6'h00;
    else
      exp_pins <= bank_one_pin_in & ~alt_func_one;

  // ==========================================================================
  // steps
  sequence s_rd_port;
    file_read && (file_addr == BANK_ONE_ADDR || file_addr == BANK_TWO_ADDR);
  endsequence
  sequence s_wr_one;
    file_write && file_addr == BANK_ONE_ADDR;
  endsequence
  sequence s_drive_all;
    direction_load_instr && file_addr == BANK_ONE_ADDR && file_wdata == 8'h00;
  endsequence

  // ==========================================================================
  // checks
  chk_top_bits_zero: assert property (s_rd_port |=> file_rdata[7:6] == 2'h0)
    else $error("port upper bits not zero");
  chk_read_pins: assert property (file_read && file_addr == BANK_ONE_ADDR
    |=> file_rdata[5:0] == exp_pins) else $error("port read mismatch");
  chk_rdata_stands: assert property (!file_read |=> $stable(file_rdata))
    else $error("read data moved");
  chk_latch_write: assert property (s_wr_one
    |=> bank_one_pin_out == ($past(file_wdata[5:0]) & OUTPUT_MASK))
    else $error("latch write wrong");
  chk_latch_holds: assert property (!(file_write && file_addr == BANK_ONE_ADDR)
    |=> $stable(bank_one_pin_out)) else $error("latch changed");
  chk_drive_latch: assert property (s_drive_all
    |=> bank_one_pin_oe == (OUTPUT_MASK & ~alt_func_one))
    else $error("drivers wrong");
  chk_reset_inputs: assert property ($fell(reset)
    |-> bank_one_pin_oe == 6'h00 && bank_two_pin_oe == 6'h00)
    else $error("driver on after reset");
  chk_timer_forced: assert property (timer_clock_source_sel
    |-> !(TIMER_BANK ? bank_two_pin_oe[TIMER_PIN] : bank_one_pin_oe[TIMER_PIN]))
    else $error("timer pin driven");
  chk_pullup_off: assert property (option_cfg[PULLUP_DISABLE_BIT]
    && !master_clear_input |-> bank_one_pullup_en == 6'h00)
    else $error("pull-up on while disabled");
  chk_clear_pullup: assert property (master_clear_input |-> bank_one_pullup_en[3])
    else $error("master clear pull-up off");
  chk_out_no_pullup: assert property ((bank_one_pullup_en & bank_one_pin_oe) == 6'h00)
    else $error("pull-up on driven pin");
  chk_wake_off: assert property (option_cfg[WAKE_DISABLE_BIT] || !sleep_mode
    |=> !pin_wake_request) else $error("wake while disabled");
  chk_wake_flag: assert property ($fell(reset)
    |=> pin_wake_flag == $past(wake_reset_cause)) else $error("wake flag wrong");
endmodule // io_port_chk

bind io_port io_port_chk #(.TIMER_BANK(TIMER_BANK), .TIMER_PIN(TIMER_PIN))
  u_io_port_chk (.mclk, .reset, .file_addr, .file_read, .file_write,
  .file_wdata, .file_rdata, .direction_load_instr, .sleep_mode,
  .wake_reset_cause, .master_clear_input, .alt_func_one, .bank_one_pin_in,
  .bank_one_pin_out, .bank_one_pin_oe, .bank_one_pullup_en, .bank_two_pin_oe,
  .option_cfg, .timer_clock_source_sel, .pin_wake_request, .pin_wake_flag);

`default_nettype wire

// *** tb/io_port_test.sv ***
// self-checking bench for the six-bit i/o port, large variant
`timescale 1ns/1ps
`default_nettype none

module io_port_test;
  import io_port_pkg::*;

  localparam logic [1:0] RD = 2'h0, WR = 2'h1, DL = 2'h2, OL = 2'h3;

  logic       mclk = 1'b0, reset = 1'b1, file_read = 1'b0, file_write = 1'b0;
  logic       direction_load_instr = 1'b0, option_load = 1'b0;
  logic       sleep_mode = 1'b0, wake_reset_cause = 1'b0;
  logic       master_clear_input = 1'b0;
  logic [4:0] file_addr = 5'h00;
  logic [7:0] file_wdata = 8'h00, file_rdata, option_cfg;
  logic [5:0] alt_func_one = 6'h00, ext_one = 6'h00, drv_one = 6'h00;
  logic [5:0] ext_two = 6'h00, drv_two = 6'h00;
  logic [5:0] alt_func_two = 6'h00;
  logic [5:0] bank_one_pin_in, bank_one_pin_out, bank_one_pin_oe;
  logic [5:0] bank_one_pullup_en, bank_two_pin_in, bank_two_pin_out;
  logic [5:0] bank_two_pin_oe;
  logic       timer_clock_source_sel, pin_wake_request, pin_wake_flag;
  int         n_fail = 0, num_checks = 0, cycles = 0;

  always #25 mclk = ~mclk;

  io_port #(.LARGE_VARIANT(1'b1), .TIMER_BANK(1'b1), .TIMER_PIN(5)) u_io_port (
    .mclk, .reset, .file_addr, .file_read, .file_write, .file_wdata,
    .file_rdata, .direction_load_instr, .option_load, .sleep_mode,
    .wake_reset_cause, .master_clear_input, .alt_func_one,
    .alt_func_two, .bank_one_pin_in, .bank_one_pin_out,
    .bank_one_pin_oe, .bank_one_pullup_en, .bank_two_pin_in,
    .bank_two_pin_out, .bank_two_pin_oe, .option_cfg,
    .timer_clock_source_sel, .pin_wake_request, .pin_wake_flag);
  pin_load u_pin_load (.pin_out(bank_one_pin_out), .pin_oe(bank_one_pin_oe),
    .pullup_en(bank_one_pullup_en), .ext_val(ext_one), .ext_drive(drv_one),
    .pin_in(bank_one_pin_in));
  pin_load u_pin_load_two (.pin_out(bank_two_pin_out),
    .pin_oe(bank_two_pin_oe), .pullup_en(6'h00), .ext_val(ext_two),
    .ext_drive(drv_two), .pin_in(bank_two_pin_in));

  // ==========================================================================
  // access and compare tasks
  task automatic op(input logic [1:0] k, input logic [4:0] a,
                    input logic [7:0] d);
    @(negedge mclk);
    file_addr = a;
    file_wdata = d;
    file_read = (k == RD);
    file_write = (k == WR);
    direction_load_instr = (k == DL);
    option_load = (k == OL);
    @(negedge mclk);
    {file_read, file_write, direction_load_instr, option_load} = 4'h0;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [5:0] got, input logic [5:0] exp);
    cmp_reg({2'h0, got}, {2'h0, exp});
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    op(RD, a, 8'h00);
    cmp_reg(file_rdata, exp);
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================================
  // scenarios
  initial
  begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    cmp_pin(bank_one_pin_oe | bank_two_pin_oe, 6'h00);
    cmp_reg(option_cfg, OPTION_RESET);
    cmp_pin(bank_one_pullup_en, 6'h00);
    drv_one = 6'h3F;
    ext_one = 6'h2A;
    op(WR, BANK_ONE_ADDR, 8'hFF);
    cmp_pin(bank_one_pin_out, OUTPUT_MASK);
    rd(BANK_ONE_ADDR, 8'h2A);
    ext_one = 6'h15;
    @(negedge mclk);
    cmp_reg(file_rdata, 8'h2A);
    rd(BANK_ONE_ADDR, 8'h15);
    rd(5'h10, 8'h00);
    op(DL, BANK_ONE_ADDR, 8'h00);
    cmp_pin(bank_one_pin_oe, OUTPUT_MASK);
    drv_one = 6'h01;
    ext_one = 6'h00;
    rd(BANK_ONE_ADDR, 8'h3E);
    drv_two = 6'h3F;
    ext_two = 6'h15;
    op(WR, BANK_TWO_ADDR, 8'hED);
    cmp_pin(bank_two_pin_out, 6'h2D);
    cmp_pin(bank_two_pin_oe, 6'h00);
    rd(BANK_TWO_ADDR, 8'h15);
    alt_func_two = 6'h01;
    rd(BANK_TWO_ADDR, 8'h14);
    alt_func_two = 6'h00;
    cmp_pin(bank_one_pin_out, OUTPUT_MASK);
    drv_one = 6'h03;
    ext_one = 6'h03;
    alt_func_one = 6'h03;
    rd(BANK_ONE_ADDR, 8'h3C);
    cmp_pin(bank_one_pin_oe, 6'h34);
    alt_func_one = 6'h00;
    ext_one = 6'h00;
    op(OL, 5'h00, 8'h20);
    cmp_pin({5'h0, timer_clock_source_sel}, 6'h01);
    op(DL, BANK_TWO_ADDR, 8'h00);
    cmp_pin(bank_two_pin_oe, 6'h1F);
    op(DL, BANK_ONE_ADDR, 8'h3E);
    cmp_pin(bank_one_pullup_en, 6'h1A);
    op(DL, BANK_ONE_ADDR, 8'h00);
    cmp_pin(bank_one_pullup_en, 6'h08);
    master_clear_input = 1'b1;
    op(OL, 5'h00, 8'h60);
    cmp_pin(bank_one_pullup_en, 6'h08);
    op(DL, BANK_ONE_ADDR, 8'h3F);
    drv_one = 6'h3F;
    rd(BANK_ONE_ADDR, 8'h00);
    sleep_mode = 1'b1;
    ext_one = 6'h0C;
    repeat (3) @(negedge mclk);
    cmp_pin({5'h0, pin_wake_request}, 6'h00);
    ext_one = 6'h0D;
    repeat (2) @(negedge mclk);
    cmp_pin({5'h0, pin_wake_request}, 6'h01);
    op(OL, 5'h00, 8'hA0);
    @(negedge mclk);
    cmp_pin({5'h0, pin_wake_request}, 6'h00);
    sleep_mode = 1'b0;
    wake_reset_cause = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    wake_reset_cause = 1'b0;
    cmp_pin({5'h0, pin_wake_flag}, 6'h01);
    rd(STATUS_ADDR, 8'h80);
    cmp_pin(bank_one_pin_oe | bank_two_pin_oe, 6'h00);
    reset = 1'b1;
    @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    cmp_pin({5'h0, pin_wake_flag}, 6'h00);
    summarize();
  end
endmodule // io_port_test

`default_nettype wire

// *** tb/pin_load.sv ***
// external circuitry model for one six-bit pin bank
`timescale 1ns/1ps
`default_nettype none

module pin_load
(
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pullup_en,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_drive,
  output logic      [5:0] pin_in
);
  // a strong outside driver wins; a released pin without pull-up floats
  // to the inverse of the latch so a stale value never reads back
  assign pin_in = (ext_drive & ext_val) | (~ext_drive & pin_oe & pin_out)
                | (~ext_drive & ~pin_oe & (pullup_en | ~pin_out));
endmodule // pin_load

`default_nettype wire
